// [hdl/pcs_pkg.sv]
// Constants and types shared by the program counter and return stack block
package pcs_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [11:0] IDX_PROGRAM_COUNTER_LOW = 12'hf82;
  localparam logic [11:0] IDX_PC_HIGH_WRITE_LATCH = 12'hf8a;
  localparam logic [11:0] IDX_POWER_CONTROL = 12'hf90;
  localparam logic [11:0] IDX_STACK_CONFIG = 12'hf91;
  localparam logic [11:0] IDX_FLAGS_SHADOW = 12'hfe4;
  localparam logic [11:0] IDX_WORKING_REG_SHADOW = 12'hfe5;
  localparam logic [11:0] IDX_BANK_SELECT_SHADOW = 12'hfe6;
  localparam logic [11:0] IDX_PC_LATCH_SHADOW = 12'hfe7;
  localparam logic [11:0] IDX_POINTER0_LOW_SHADOW = 12'hfe8;
  localparam logic [11:0] IDX_POINTER0_HIGH_SHADOW = 12'hfe9;
  localparam logic [11:0] IDX_POINTER1_LOW_SHADOW = 12'hfea;
  localparam logic [11:0] IDX_POINTER1_HIGH_SHADOW = 12'hfeb;
  localparam logic [11:0] IDX_STACK_POINTER = 12'hfed;
  localparam logic [11:0] IDX_STACK_TOP_LOW = 12'hfee;
  localparam logic [11:0] IDX_STACK_TOP_HIGH = 12'hfef;

  // Offset within a 128-byte data bank
  localparam int BANK_OFS_W = 7;

  // Field positions
  localparam int PWR_UNF_BIT = 0;
  localparam int PWR_OVF_BIT = 1;
  localparam int CFG_STACK_RESET_BIT = 0;

  // Values after reset
  localparam logic [7:0] RST_PROGRAM_COUNTER_LOW = 8'h00;
  localparam logic [6:0] RST_PC_HIGH_WRITE_LATCH = 7'h00;
  localparam logic [4:0] RST_STACK_POINTER = 5'h1f;
  localparam logic RST_STACK_RESET_ENABLE = 1'b1;
  localparam logic [7:0] RST_SHADOW = 8'h00;

  // Stack pointer landmarks
  localparam logic [4:0] SP_EMPTY = 5'h1f;
  localparam logic [4:0] SP_FULL = 5'h0f;

  // Operations requested by instruction execution and interrupt logic
  typedef enum logic [3:0] {
    PCS_OP_NONE = 4'h0,
    PCS_OP_STEP = 4'h1,
    PCS_OP_WRITE_PCL = 4'h2,
    PCS_OP_CALL = 4'h3,
    PCS_OP_COMPUTED_CALL = 4'h4,
    PCS_OP_WORKING_REG_BRANCH = 4'h5,
    PCS_OP_RELATIVE_BRANCH = 4'h6,
    PCS_OP_INTERRUPT = 4'h7,
    PCS_OP_RETURN = 4'h8,
    PCS_OP_RETURN_WITH_LITERAL = 4'h9,
    PCS_OP_RETURN_FROM_INTERRUPT = 4'ha
  } pcs_op_t;

endpackage

// [hdl/pcs_stack_mem.sv]
// Return stack storage with registered read data and write-through forwarding
module pcs_stack_mem
  import pcs_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_q;

  wire fwd = we && (waddr == raddr);

  // Stack contents are not cleared by reset
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Forwarding keeps the top entry current the cycle after a push
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else if (ce) begin
      rdata_q <= fwd ? wdata : mem[raddr];
    end
  end

  assign rdata = rdata_q;

endmodule

// [hdl/pcs_core.sv]
// Program counter sequencing and hardware return stack with an APB register slave
// What this block does
// - Keeps a 15-bit program counter; low byte readable, upper seven bits only from latch.
// - Every reset source clears the whole program counter to zero.
// - Writing the low byte loads bits 14:8 from the latch in the same step.
// - Absolute call takes eleven operand bits and latch bits 6:3.
// - Computed call takes low byte from working register, upper byte from latch.
// - Working-register branch loads incremented address plus unsigned working register.
// - Relative branch loads incremented address plus signed operand.
// - Return stack holds 16 entries of 15 bits, apart from other memories.
// - Calls and interrupts push; the three return kinds pop.
// - Pushes and pops change the high-byte latch only through a stack reset, which clears it.
// - With stack reset disabled the stack wraps and overwrites oldest entries.
// - Overflow and underflow flags are set whether or not reset is enabled.
// - Top-of-stack registers read and write the entry the pointer selects.
// - Stack pointer is five bits so overflow and underflow show.
// - Push increments pointer then writes; pop reads then decrements.
// - Empty pointer value and reset value is 0x1F; first push selects 0x00.
// - Push on full stack gives 0x10, or resets without overwriting entry 0x00.
// - Low byte and latch registers answer at the same offset in every bank.
// - With stack reset enabled, overflow or underflow resets the device and flags it.
//
// Design decision made here: the APB slave port.
module pcs_core
  import pcs_pkg::*;
#(
  parameter int PC_W = 15,
  parameter int DEPTH = 16,
  parameter int SP_W = 5
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pcs_op_t core_op,
  input wire logic [PC_W-1:0] core_operand,
  input wire logic [7:0] working_register,
  output logic [PC_W-1:0] pc,
  output logic [SP_W-1:0] stack_pointer,
  output logic stack_reset_req
);

  localparam int AW = $clog2(DEPTH);

  // Register state
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic [6:0] latch_q;
  logic [6:0] latch_d;
  logic [SP_W-1:0] sp_q;
  logic [SP_W-1:0] sp_d;
  logic ovf_q;
  logic ovf_d;
  logic unf_q;
  logic unf_d;
  logic stack_reset_enable_q;
  logic [7:0] shadow_q [8];
  logic rst_req_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Stack port signals
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [PC_W-1:0] mem_wdata;
  logic [PC_W-1:0] tos;

  // Sequencing helpers
  logic do_push;
  logic do_pop;
  logic [PC_W-1:0] push_val;
  logic ovf_set;
  logic unf_set;
  logic stk_rst;

  function automatic logic [7:0] shadow_mask(input logic [2:0] slot);
    case (slot)
      3'd0: shadow_mask = 8'h07;
      3'd2: shadow_mask = 8'h1f;
      3'd3: shadow_mask = 8'h7f;
      default: shadow_mask = 8'hff;
    endcase
  endfunction

  // Address decode
  wire [11:0] idx = paddr[13:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_pcl = aligned &&
    (idx[BANK_OFS_W-1:0] == IDX_PROGRAM_COUNTER_LOW[BANK_OFS_W-1:0]);
  wire hit_latch = aligned &&
    (idx[BANK_OFS_W-1:0] == IDX_PC_HIGH_WRITE_LATCH[BANK_OFS_W-1:0]);
  wire hit_sp = aligned && (idx == IDX_STACK_POINTER);
  wire hit_stack_top_low = aligned && (idx == IDX_STACK_TOP_LOW);
  wire hit_stack_top_high = aligned && (idx == IDX_STACK_TOP_HIGH);
  wire hit_pwr = aligned && (idx == IDX_POWER_CONTROL);
  wire hit_cfg = aligned && (idx == IDX_STACK_CONFIG);
  wire hit_shadow = aligned && (idx >= IDX_FLAGS_SHADOW) && (idx <= IDX_POINTER1_HIGH_SHADOW);
  wire [2:0] shadow_slot = idx[2:0] ^ 3'b100;
  wire mapped = hit_pcl || hit_latch || hit_sp || hit_stack_top_low || hit_stack_top_high ||
    hit_pwr || hit_cfg || hit_shadow;

  // A write lands at the edge where the master sees pready high
  wire bus_done = psel && penable && pready_q;
  wire wr_en = bus_done && pwrite && mapped;
  wire rd_take = psel && penable && !pready_q;

  // Read data
  wire [7:0] pwr_view = {6'h00, ovf_q, unf_q};
  wire [7:0] rd_byte =
    hit_pcl ? pc_q[7:0] :
    hit_latch ? {1'b0, latch_q} :
    hit_sp ? {3'b000, sp_q} :
    hit_stack_top_low ? tos[7:0] :
    hit_stack_top_high ? {1'b0, tos[14:8]} :
    hit_pwr ? pwr_view :
    hit_cfg ? {7'h00, stack_reset_enable_q} :
    hit_shadow ? (shadow_q[shadow_slot] & shadow_mask(shadow_slot)) :
    8'h00;

  // Arithmetic on the program counter
  wire [PC_W-1:0] pc_inc = pc_q + 15'd1;
  wire [PC_W-1:0] w_ext = {7'h00, working_register};
  wire [PC_W-1:0] bra_ext = {{6{core_operand[8]}}, core_operand[8:0]};
  wire [SP_W-1:0] sp_inc = sp_q + 5'd1;
  wire [SP_W-1:0] sp_dec = sp_q - 5'd1;
  wire core_busy = (core_op != PCS_OP_NONE);

  // Operation decode; the core always wins over a bus write to PC, pointer or stack
  always_comb begin
    pc_d = pc_q;
    do_push = 1'b0;
    do_pop = 1'b0;
    push_val = pc_inc;
    case (core_op)
      PCS_OP_STEP: begin
        pc_d = pc_inc;
      end
      PCS_OP_WRITE_PCL: begin
        pc_d = {latch_q, core_operand[7:0]};
      end
      PCS_OP_CALL: begin
        do_push = 1'b1;
        pc_d = {latch_q[6:3], core_operand[10:0]};
      end
      PCS_OP_COMPUTED_CALL: begin
        do_push = 1'b1;
        pc_d = {latch_q, working_register};
      end
      PCS_OP_WORKING_REG_BRANCH: begin
        pc_d = pc_inc + w_ext;
      end
      PCS_OP_RELATIVE_BRANCH: begin
        pc_d = pc_inc + bra_ext;
      end
      PCS_OP_INTERRUPT: begin
        do_push = 1'b1;
        push_val = pc_q;
        pc_d = core_operand;
      end
      PCS_OP_RETURN, PCS_OP_RETURN_WITH_LITERAL, PCS_OP_RETURN_FROM_INTERRUPT: begin
        do_pop = 1'b1;
        pc_d = tos;
      end
      default: begin
        if (wr_en && hit_pcl) begin
          pc_d = {latch_q, pwdata[7:0]};
        end
      end
    endcase
  end

  // Stack pointer, storage and overflow handling
  always_comb begin
    sp_d = sp_q;
    mem_we = 1'b0;
    mem_waddr = sp_inc[AW-1:0];
    mem_wdata = push_val;
    ovf_set = 1'b0;
    unf_set = 1'b0;
    stk_rst = 1'b0;
    if (do_push) begin
      ovf_set = (sp_q == SP_FULL);
      if (ovf_set && stack_reset_enable_q) begin
        stk_rst = 1'b1;
      end else begin
        sp_d = sp_inc;
        mem_we = 1'b1;
      end
    end else if (do_pop) begin
      unf_set = (sp_q == SP_EMPTY);
      sp_d = sp_dec;
      stk_rst = unf_set && stack_reset_enable_q;
    end else if (!core_busy && wr_en) begin
      if (hit_sp) begin
        sp_d = pwdata[SP_W-1:0];
      end
      mem_waddr = sp_q[AW-1:0];
      if (hit_stack_top_low) begin
        mem_we = 1'b1;
        mem_wdata = {tos[14:8], pwdata[7:0]};
      end
      if (hit_stack_top_high) begin
        mem_we = 1'b1;
        mem_wdata = {pwdata[6:0], tos[7:0]};
      end
    end
  end

  // The latch changes through the bus or a stack reset, which clears it; pushes and pops never load it
  assign latch_d = (wr_en && hit_latch) ? pwdata[6:0] : latch_q;

  // Hardware set wins over a software clear in the same cycle
  assign ovf_d = ((wr_en && hit_pwr) ? pwdata[PWR_OVF_BIT] : ovf_q) | ovf_set;
  assign unf_d = ((wr_en && hit_pwr) ? pwdata[PWR_UNF_BIT] : unf_q) | unf_set;

  // Entry count follows the pointer width's low bits; the top bit marks wrap
  pcs_stack_mem #(
    .DEPTH(DEPTH),
    .WIDTH(PC_W),
    .AW(AW)
  ) u_stack (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(stk_rst ? RST_STACK_POINTER[AW-1:0] : sp_d[AW-1:0]),
    .rdata(tos)
  );

  // Program counter, latch and pointer; a stack reset behaves like any reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_q <= {RST_PC_HIGH_WRITE_LATCH, RST_PROGRAM_COUNTER_LOW};
      latch_q <= RST_PC_HIGH_WRITE_LATCH;
      sp_q <= RST_STACK_POINTER;
    end else if (ce) begin
      if (stk_rst) begin
        pc_q <= {RST_PC_HIGH_WRITE_LATCH, RST_PROGRAM_COUNTER_LOW};
        latch_q <= RST_PC_HIGH_WRITE_LATCH;
        sp_q <= RST_STACK_POINTER;
      end else begin
        pc_q <= pc_d;
        latch_q <= latch_d;
        sp_q <= sp_d;
      end
    end
  end

  // Flags survive the stack reset so software can see its cause
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      stack_reset_enable_q <= RST_STACK_RESET_ENABLE;
      rst_req_q <= 1'b0;
    end else if (ce) begin
      ovf_q <= ovf_d;
      unf_q <= unf_d;
      if (wr_en && hit_cfg) begin
        stack_reset_enable_q <= pwdata[CFG_STACK_RESET_BIT];
      end
      rst_req_q <= stk_rst;
    end
  end

  // Shadow copies are plain storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 8; i++) begin
        shadow_q[i] <= RST_SHADOW;
      end
    end else if (ce && wr_en && hit_shadow) begin
      shadow_q[shadow_slot] <= pwdata[7:0] & shadow_mask(shadow_slot);
    end
  end

  // Bus answer: one wait state, data and error taken in the first access cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      if (rd_take) begin
        pready_q <= 1'b1;
        prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr_q <= !mapped;
      end else begin
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pc = pc_q;
  assign stack_pointer = sp_q;
  assign stack_reset_req = rst_req_q;

endmodule

// [verif/pcs_core_sva.sv]
// Port checker for the program counter and return stack
module pcs_core_sva
  import pcs_pkg::*;
#(
  parameter int PC_W = 15,
  parameter int SP_W = 5
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire pcs_op_t core_op,
  input wire logic [PC_W-1:0] core_operand,
  input wire logic [7:0] working_register,
  input wire logic [PC_W-1:0] pc,
  input wire logic [SP_W-1:0] stack_pointer,
  input wire logic stack_reset_req
);
  wire logic push_w;
  wire logic pop_w;
  assign push_w = core_op inside {PCS_OP_CALL, PCS_OP_COMPUTED_CALL, PCS_OP_INTERRUPT};
  assign pop_w = core_op inside {PCS_OP_RETURN, PCS_OP_RETURN_WITH_LITERAL,
    PCS_OP_RETURN_FROM_INTERRUPT};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_bus_wait; psel && penable && !pready |=> pready; endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus answer late");
  property p_bus_pulse; pready |=> !pready; endproperty
  a_bus_pulse: assert property (p_bus_pulse) else $error("ready held too long");
  // Overflow with reset enabled clears pc, so a full stack is left out
  property p_call; core_op == PCS_OP_CALL && stack_pointer != SP_FULL
    |=> pc[10:0] == $past(core_operand[10:0]); endproperty
  a_call: assert property (p_call) else $error("call target wrong");
  property p_ccall; core_op == PCS_OP_COMPUTED_CALL && stack_pointer != SP_FULL
    |=> pc[7:0] == $past(working_register); endproperty
  a_ccall: assert property (p_ccall) else $error("computed call low byte wrong");
  property p_wbr; core_op == PCS_OP_WORKING_REG_BRANCH
    |=> pc == $past(pc) + 15'h1 + $past(working_register); endproperty
  a_wbr: assert property (p_wbr) else $error("register branch wrong");
  property p_rbr; core_op == PCS_OP_RELATIVE_BRANCH |=> pc == $past(pc) + 15'h1
    + {{6{$past(core_operand[8])}}, $past(core_operand[8:0])}; endproperty
  a_rbr: assert property (p_rbr) else $error("relative branch wrong");
  property p_push; push_w && stack_pointer != SP_FULL
    |=> stack_pointer == $past(stack_pointer) + 5'h01; endproperty
  a_push: assert property (p_push) else $error("push pointer wrong");
  property p_pop; pop_w && stack_pointer != SP_EMPTY
    |=> stack_pointer == $past(stack_pointer) - 5'h01; endproperty
  a_pop: assert property (p_pop) else $error("pop pointer wrong");
  property p_ovf; push_w && stack_pointer == SP_FULL
    |=> stack_reset_req || stack_pointer == 5'h10; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow handling wrong");
  property p_unf; pop_w && stack_pointer == SP_EMPTY
    |=> stack_reset_req || stack_pointer == 5'h1e; endproperty
  a_unf: assert property (p_unf) else $error("underflow handling wrong");
  property p_srst; stack_reset_req |-> pc == '0 && stack_pointer == SP_EMPTY; endproperty
  a_srst: assert property (p_srst) else $error("stack reset incomplete");
endmodule

// [verif/pcs_core_model.sv]
// Instruction execution side: issues one operation per call
module pcs_core_model
  import pcs_pkg::*;
(
  input wire logic clk,
  output pcs_op_t core_op,
  output logic [14:0] core_operand,
  output logic [7:0] working_register
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    core_op = PCS_OP_NONE;
    core_operand = 15'h2aaa;
    working_register = 8'h55;
  end
  // Idle operands flip so stale values are never mistaken for live ones
  task automatic issue(input pcs_op_t op, input logic [14:0] v, input logic [7:0] w);
    @(posedge clk);
    core_op <= op;
    core_operand <= v;
    working_register <= w;
    @(posedge clk);
    core_op <= PCS_OP_NONE;
    core_operand <= ~v;
    working_register <= ~w;
  endtask
endmodule

// [verif/program_counter_and_return_stack_tb_top.sv]
// Testbench top for the program counter and return stack
module program_counter_and_return_stack_tb_top import pcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pcs_op_t core_op;
  logic [14:0] core_operand;
  logic [7:0] working_register;
  logic [14:0] pc;
  logic [4:0] stack_pointer;
  logic stack_reset_req;
  int n_mismatch = 0;
  int checks = 0;
  logic [31:0] rd;
  logic er;
  pcs_op_t ops [9] = '{PCS_OP_STEP, PCS_OP_CALL, PCS_OP_COMPUTED_CALL,
    PCS_OP_WORKING_REG_BRANCH, PCS_OP_RELATIVE_BRANCH, PCS_OP_INTERRUPT,
    PCS_OP_RETURN_FROM_INTERRUPT, PCS_OP_RETURN_WITH_LITERAL, PCS_OP_RETURN};
  logic [14:0] opr [9] = '{15'h0, 15'h07ab, 15'h0, 15'h0, 15'h01f0, 15'h0004, 15'h0, 15'h0, 15'h0};
  logic [7:0] wv [9] = '{8'h00, 8'h00, 8'h34, 8'hf0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [14:0] epc [9] = '{15'h5513, 15'h57ab, 15'h5534, 15'h5625, 15'h5616, 15'h0004,
    15'h5616, 15'h57ac, 15'h5514};
  logic [4:0] esp [9] = '{5'h1f, 5'h00, 5'h01, 5'h01, 5'h01, 5'h02, 5'h01, 5'h00, 5'h1f};
  always #20 clk = ~clk;
  pcs_core u_pcs_core (.clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_op(core_op), .core_operand(core_operand),
    .working_register(working_register), .pc(pc), .stack_pointer(stack_pointer),
    .stack_reset_req(stack_reset_req));
  pcs_core_model u_pcs_core_model (.clk(clk), .core_op(core_op), .core_operand(core_operand),
    .working_register(working_register));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk($sformatf("register %h", idx), exp, rd);
  endtask
  task automatic op(input pcs_op_t o, input logic [14:0] v, input logic [7:0] w,
    input logic [14:0] e_pc, input logic [4:0] e_sp);
    u_pcs_core_model.issue(o, v, w);
    #1;
    chk("pc", {17'h0, e_pc}, {17'h0, pc});
    chk("pointer", {27'h0, e_sp}, {27'h0, stack_pointer});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rchk(IDX_PROGRAM_COUNTER_LOW, 32'h00);
    rchk(IDX_PC_HIGH_WRITE_LATCH, 32'h00);
    rchk(IDX_STACK_POINTER, 32'h1f);
    apb(1'b1, 12'h00a, 8'h55);
    rchk(IDX_PC_HIGH_WRITE_LATCH, 32'h55);
    apb(1'b1, IDX_PROGRAM_COUNTER_LOW, 8'h12);
    #1 chk("pc", 32'h5512, {17'h0, pc});
    for (int i = 0; i < 9; i++) begin
      op(ops[i], opr[i], wv[i], epc[i], esp[i]);
    end
    rchk(IDX_PC_HIGH_WRITE_LATCH, 32'h55);
    rchk(IDX_PROGRAM_COUNTER_LOW, 32'h14);
    rchk(12'hf8c, 32'h00);
    chk("slverr", 32'h1, {31'h0, er});
    op(PCS_OP_CALL, 15'h0123, 8'h00, 15'h5123, 5'h00);
    rchk(IDX_STACK_TOP_LOW, 32'h15);
    rchk(IDX_STACK_TOP_HIGH, 32'h55);
    apb(1'b1, IDX_STACK_TOP_LOW, 8'h21);
    apb(1'b1, IDX_STACK_TOP_HIGH, 8'h33);
    op(PCS_OP_RETURN, 15'h0, 8'h00, 15'h3321, 5'h1f);
    // Circular stack: the seventeenth push lands on entry 0
    apb(1'b1, IDX_STACK_CONFIG, 8'h00);
    for (int i = 0; i < 17; i++) begin
      op(PCS_OP_INTERRUPT, 15'(256 + i), 8'h00, 15'(256 + i), 5'(i));
    end
    rchk(IDX_STACK_TOP_LOW, 32'h0f);
    rchk(IDX_POWER_CONTROL, 32'h02);
    apb(1'b1, IDX_STACK_POINTER, 8'h1f);
    op(PCS_OP_RETURN, 15'h0, 8'h00, 15'h010e, 5'h1e);
    rchk(IDX_POWER_CONTROL, 32'h03);
    apb(1'b1, IDX_STACK_CONFIG, 8'h01);
    apb(1'b1, IDX_STACK_POINTER, 8'h0f);
    op(PCS_OP_CALL, 15'h0001, 8'h00, 15'h0000, 5'h1f);
    chk("reset request", 32'h1, {31'h0, stack_reset_req});
    rchk(IDX_PC_HIGH_WRITE_LATCH, 32'h00);
    apb(1'b1, IDX_STACK_POINTER, 8'h00);
    rchk(IDX_STACK_TOP_LOW, 32'h0f);
    // Upper operand bits must be ignored; the cleared latch supplies bits 14:8
    op(PCS_OP_WRITE_PCL, 15'h7f77, 8'h00, 15'h0077, 5'h00);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rchk(IDX_STACK_POINTER, 32'h1f);
    chk("pc", 32'h0, {17'h0, pc});
    give_verdict();
  end
endmodule
bind pcs_core pcs_core_sva #(.PC_W(PC_W), .SP_W(SP_W)) u_pcs_core_sva (.clk(clk),
  .arst_n(arst_n), .psel(psel), .penable(penable), .pready(pready), .core_op(core_op),
  .core_operand(core_operand), .working_register(working_register), .pc(pc),
  .stack_pointer(stack_pointer), .stack_reset_req(stack_reset_req));
